// >>> common/pefs_defines.vh
`ifndef PEFS_DEFINES_VH
`define PEFS_DEFINES_VH

// register offset of the function select register
`define PEFS_FSEL_OFFSET 8'h0a

// field positions
`define PEFS_BIT_NOACC 7
`define PEFS_BIT_PIPE 5
`define PEFS_BIT_BUS_TIMING_CLOCK_DIS 4
`define PEFS_BIT_LSTR 3
`define PEFS_BIT_RDW 2

// implemented bits mask
`define PEFS_IMPL_MASK 8'hbc
// bits governed by the write-once / write-never / anytime scheme
`define PEFS_ONCE_MASK 8'hac
// bit governed by normal+special anytime, emulation never
`define PEFS_BUS_TIMING_CLOCK_MASK 8'h10

// operating modes {c,b,a}
`define PEFS_MODE_SPECIAL_SINGLE 3'h0
`define PEFS_MODE_EMUL_NARROW 3'h1
`define PEFS_MODE_SPECIAL_TEST 3'h2
`define PEFS_MODE_EMUL_WIDE 3'h3
`define PEFS_MODE_NORMAL_SINGLE 3'h4
`define PEFS_MODE_NORMAL_NARROW 3'h5
`define PEFS_MODE_PERIPHERAL 3'h6
`define PEFS_MODE_NORMAL_WIDE 3'h7

// reset contents per mode
`define PEFS_RST_SPECIAL_SINGLE 8'h00
`define PEFS_RST_SPECIAL_TEST 8'h2c
`define PEFS_RST_PERIPHERAL 8'h00
`define PEFS_RST_EMUL 8'hac
`define PEFS_RST_NORMAL_SINGLE 8'h10
`define PEFS_RST_NORMAL_EXP 8'h00

`endif

// >>> sim/pefs_ext_dev.sv
`default_nettype none
module pefs_ext_dev (
  input wire logic clk_sys,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv = 8'h5a;
  // released pads flip each cycle, never a stale level
  always @(posedge clk_sys) drv <= ~drv;
  assign pin_in = (pin_out & pin_oe) | (drv & ~pin_oe);
endmodule
`default_nettype wire

// >>> sim/pefs_top_asserts.sv
`default_nettype none
module pefs_top_chk #(
  parameter ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_access,
  input wire logic [7:0] port_e_direction,
  input wire logic free_cycle,
  input wire logic pipe_status_high,
  input wire logic pipe_status_low,
  input wire logic read_write,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [2:0] mode,
  input wire logic [7:0] port_e_function_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic bus = !(mode == 3'h0 || mode == 3'h4 || mode == 3'h6);
  wire logic in_map = mode == 3'h0 || mode == 3'h2 || mode == 3'h4;
  wire logic hit = (reg_rd || reg_wr) && reg_addr == 8'h0a;
  wire logic [7:0] fs = port_e_function_select;
  property p_rd_data;
    reg_rd && reg_addr == 8'h0a && in_map |=> reg_rdata == $past(fs);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle read data");
  property p_echo;
    hit && !in_map |=> ext_access;
  endproperty
  a_echo: assert property (p_echo) else $error("no echo");
  property p_frozen;
    !in_map |=> $stable(fs);
  endproperty
  a_frozen: assert property (p_frozen) else $error("unmapped store");
  property p_bus_timing_clock;
    1'b1 |=> pin_oe[4] == ($past(fs[4]) ? $past(port_e_direction[4]) : 1'b1);
  endproperty
  a_bus_timing_clock: assert property (p_bus_timing_clock) else $error("clock pin oe");
  property p_noacc;
    bus && !fs[7] |=> pin_oe[7] && pin_out[7] == $past(free_cycle);
  endproperty
  a_noacc: assert property (p_noacc) else $error("free cycle pin");
  property p_pipe;
    bus && fs[5] |=> pin_oe[6:5] == 2'b11 &&
      pin_out[6:5] == $past({pipe_status_high, pipe_status_low});
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipe pins");
  property p_rdw;
    bus && fs[2] |=> pin_oe[2] && pin_out[2] == $past(read_write);
  endproperty
  a_rdw: assert property (p_rdw) else $error("rw pin");
  property p_inert;
    !bus |=> pin_oe[7:5] == $past(port_e_direction[7:5]);
  endproperty
  a_inert: assert property (p_inert) else $error("inert bits");
endmodule
bind pefs_top pefs_top_chk #(.ADDR_W(ADDR_W)) pefs_top_chk_inst (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_access(ext_access),
  .port_e_direction(port_e_direction), .free_cycle(free_cycle),
  .pipe_status_high(pipe_status_high), .pipe_status_low(pipe_status_low),
  .read_write(read_write), .pin_out(pin_out), .pin_oe(pin_oe), .mode(mode),
  .port_e_function_select(port_e_function_select));
`default_nettype wire

// >>> sim/tb_port_e_function_select.sv
`default_nettype none
module tb_port_e_function_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0] mode_pins = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, dat = 0, dir = 0, r, d, x;
  logic fc = 0, ph = 0, pl = 0, ec = 0, cs = 0, ba = 0, lb = 0, rw = 0, te = 0;
  wire logic [7:0] reg_rdata, pin_out, pin_oe, pin_in, pfs, pst;
  wire logic ext_access;
  wire logic [2:0] mode;
  int n_fail = 0, cmp_count = 0;
  pefs_top pefs_top_inst (.clk_sys(clk_sys), .rst(rst), .mode_pins(mode_pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_access(ext_access), .port_e_data(dat),
    .port_e_direction(dir), .pin_in(pin_in), .free_cycle(fc), .pipe_status_high(ph),
    .pipe_status_low(pl), .bus_timing_clock(ec), .clock_stretch_control(cs),
    .bus_cycle_active(ba), .low_byte_strobe(lb), .read_write(rw), .tag_enable(te),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_state(pst), .low_tag_input(),
    .mode(mode), .port_e_function_select(pfs));
  pefs_ext_dev pefs_ext_dev_inst (.clk_sys(clk_sys), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in));
  function automatic logic [7:0] rv(input logic [2:0] m);
    case (m)
      3'h1, 3'h3: rv = 8'hac;
      3'h2: rv = 8'h2c;
      3'h4: rv = 8'h10;
      default: rv = 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] eoe(input logic [2:0] m, input logic [7:0] q, e,
    input logic t);
    logic bus;
    bus = !(m == 3'h0 || m == 3'h4 || m == 3'h6);
    eoe = e & 8'hfc;
    if (bus && !q[7]) eoe[7] = 1'b1;
    if (bus && q[5]) eoe[6:5] = 2'b11;
    if (!q[4]) eoe[4] = 1'b1;
    if (bus && q[3] && m != 3'h5) eoe[3] = !t;
    if (bus && q[2]) eoe[2] = 1'b1;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic conclude;
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
  initial begin
    void'($urandom(90086));
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_sys);
      mode_pins <= m[2:0];
      rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      r = rv(m[2:0]);
      #1 chk(pfs, r);
      chk({5'h00, mode}, {5'h00, m[2:0]});
      rd(8'h0a, d);
      chk(d, (m == 0 || m == 2 || m == 4) ? r : 8'h00);
      x = (m == 2) ? 8'hff : 8'($urandom);
      wr(8'h0a, x);
      if (m == 0 || m == 2 || m == 4) r = x & 8'hbc;
      chk(pfs, r);
      x = 8'($urandom);
      wr(8'h0a, x);
      if (m == 0 || m == 2) r = x & 8'hbc;
      if (m == 4) r = (r & 8'hac) | (x & 8'h10);
      chk(pfs, r);
      wr(8'h0b, 8'hff);
      rd(8'h0b, d);
      chk(d | (pfs ^ r), 8'h00);
      repeat (4) begin
        @(posedge clk_sys);
        {dat, dir, fc, ph, pl, ec, cs, ba, lb, rw, te} <= 25'($urandom);
        repeat (2) @(posedge clk_sys);
        #1 chk(pin_oe, eoe(m[2:0], r, dir, te & ec));
        if (!r[4]) chk({7'h00, pin_out[4]}, {7'h00, ec & (~cs | ba)});
        repeat (2) @(posedge clk_sys);
        #1 chk(pst & pin_oe, pin_out & pin_oe);
      end
    end
    conclude;
  end
endmodule
`default_nettype wire

// >>> verilog/pefs_pin_mux.v
`default_nettype none

module pefs_pin_mux #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] alt_sel,
  input wire [WIDTH-1:0] alt_value,
  input wire [WIDTH-1:0] alt_oe,
  input wire [WIDTH-1:0] gpio_value,
  input wire [WIDTH-1:0] gpio_dir,
  input wire [WIDTH-1:0] gpio_capable,
  output wire [WIDTH-1:0] pin_value,
  output wire [WIDTH-1:0] pin_oe
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      assign pin_value[i] = alt_sel[i] ? alt_value[i] : gpio_value[i];
      assign pin_oe[i] = alt_sel[i] ? alt_oe[i] : (gpio_dir[i] & gpio_capable[i]);
    end
  endgenerate

endmodule

`default_nettype wire

// >>> verilog/pefs_top.v
// Function
// - test/emulation reset selects bus control pins
// - normal single-chip reset: all general I/O
// - normal expanded reset: E clock and free-cycle flag on pin 7
// - alternate function overrides direction bit
// - register readable whenever in map
// - expanded/peripheral modes echo access externally
// - control bits once/never/anytime by mode class
// - free-cycle bit low drives pin 7
// - bits other than E clock disable inert in single-chip/peripheral modes
// - pipe enable drives pins 6:5 queue state
// - E clock on pin 4 unless disabled
// - E clock disable: never in emulation
// - low strobe on pin 3, tag sampling
// - low strobe inert in normal narrow/single/peripheral
// - read/write enable drives pin 2
`include "pefs_defines.vh"
`default_nettype none

module pefs_top #(
  parameter ADDR_W = 8
) (
  input wire clk_sys,
  input wire rst,
  input wire [2:0] mode_pins,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg ext_access,
  input wire [7:0] port_e_data,
  input wire [7:0] port_e_direction,
  input wire [7:0] pin_in,
  input wire free_cycle,
  input wire pipe_status_high,
  input wire pipe_status_low,
  input wire bus_timing_clock,
  input wire clock_stretch_control,
  input wire bus_cycle_active,
  input wire low_byte_strobe,
  input wire read_write,
  input wire tag_enable,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe,
  output reg [7:0] pin_state,
  output reg low_tag_input,
  output reg [2:0] mode,
  output reg [7:0] port_e_function_select
);

  reg [2:0] mode_meta;
  reg [2:0] mode_sync;
  reg [7:0] pin_meta;
  reg once_used;
  reg bus_timing_clock_prev;
  reg strobe_hold;
  reg [7:0] next_reset_value;
  reg [7:0] write_mask;
  reg [7:0] alt_sel;
  reg [7:0] alt_value;
  reg [7:0] alt_oe;
  wire [7:0] mux_value;
  wire [7:0] mux_oe;
  wire is_emul;
  wire is_special;
  wire is_normal;
  wire bus_mode;
  wire in_map;
  wire hit;
  wire bus_timing_clock_rise;
  wire bus_timing_clock_fall;
  wire bus_timing_clock_out;
  wire free_cycle_output_enable;
  wire pipe_status_output_enable;
  wire bus_clock_pin_disable;
  wire low_strobe_enable;
  wire read_write_pin_enable;

  assign free_cycle_output_enable = port_e_function_select[`PEFS_BIT_NOACC];
  assign pipe_status_output_enable = port_e_function_select[`PEFS_BIT_PIPE];
  assign bus_clock_pin_disable = port_e_function_select[`PEFS_BIT_BUS_TIMING_CLOCK_DIS];
  assign low_strobe_enable = port_e_function_select[`PEFS_BIT_LSTR];
  assign read_write_pin_enable = port_e_function_select[`PEFS_BIT_RDW];

  // mode class: emulation has c=0,a=1; peripheral counts as special
  assign is_emul = ~mode[2] & mode[0];
  assign is_special = (~mode[2] & ~mode[0]) | (mode == `PEFS_MODE_PERIPHERAL);
  assign is_normal = mode[2] & (mode != `PEFS_MODE_PERIPHERAL);
  // bus control bits only act in bus-carrying modes
  assign bus_mode = (mode != `PEFS_MODE_SPECIAL_SINGLE) &&
                    (mode != `PEFS_MODE_NORMAL_SINGLE) &&
                    (mode != `PEFS_MODE_PERIPHERAL);
  // out of the map in expanded and special peripheral modes
  assign in_map = ~mode[0] & (mode != `PEFS_MODE_PERIPHERAL);
  assign hit = (reg_addr == `PEFS_FSEL_OFFSET);

  // straps and pins come from outside the clock domain
  // not reset: the straps must pass through while reset is held
  always @(posedge clk_sys) begin
    mode_meta <= mode_pins;
    mode_sync <= mode_meta;
    pin_meta <= pin_in;
    pin_state <= pin_meta;
  end

  always @* begin
    case (mode_sync)
      // pipe, strobe and read/write on out of reset
      `PEFS_MODE_SPECIAL_TEST: next_reset_value = `PEFS_RST_SPECIAL_TEST;
      // emulation also sets the free-cycle bit
      `PEFS_MODE_EMUL_NARROW: next_reset_value = `PEFS_RST_EMUL;
      `PEFS_MODE_EMUL_WIDE: next_reset_value = `PEFS_RST_EMUL;
      // normal single chip disables the E clock pin; special single resets to all zeros
      `PEFS_MODE_NORMAL_SINGLE: next_reset_value = `PEFS_RST_NORMAL_SINGLE;
      // expanded keeps the E clock and the free-cycle flag on pin 7
      `PEFS_MODE_NORMAL_NARROW: next_reset_value = `PEFS_RST_NORMAL_EXP;
      `PEFS_MODE_NORMAL_WIDE: next_reset_value = `PEFS_RST_NORMAL_EXP;
      `PEFS_MODE_PERIPHERAL: next_reset_value = `PEFS_RST_PERIPHERAL;
      default: next_reset_value = `PEFS_RST_SPECIAL_SINGLE;
    endcase
  end

  always @* begin
    write_mask = 8'h00;
    // once in normal, never in emulation, anytime in special
    if (is_special || (is_normal && !once_used)) begin
      write_mask = write_mask | `PEFS_ONCE_MASK;
    end
    // E clock disable never writable in emulation
    if (!is_emul) begin
      write_mask = write_mask | `PEFS_BUS_TIMING_CLOCK_MASK;
    end
    // unimplemented bits never take a write
    write_mask = write_mask & `PEFS_IMPL_MASK;
  end

  // mode is caught while reset is held, straps already synchronised
  always @(posedge clk_sys) begin
    if (rst) begin
      mode <= mode_sync;
      port_e_function_select <= next_reset_value;
      once_used <= 1'b0;
    end else if (reg_wr && hit && in_map) begin
      port_e_function_select <= (port_e_function_select & ~write_mask) |
                                (reg_wdata & write_mask);
      // first normal-mode write spends the single chance
      if (is_normal) begin
        once_used <= 1'b1;
      end
    end
  end

  // readable whenever in map, one cycle later
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && hit && in_map) begin
      reg_rdata <= port_e_function_select & `PEFS_IMPL_MASK;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // access to the address goes out to the external bus instead
  always @(posedge clk_sys) begin
    if (rst) begin
      ext_access <= 1'b0;
    end else begin
      ext_access <= (reg_rd | reg_wr) & hit & ~in_map;
    end
  end

  assign bus_timing_clock_rise = bus_timing_clock & ~bus_timing_clock_prev;
  assign bus_timing_clock_fall = ~bus_timing_clock & bus_timing_clock_prev;
  // stretch control gates the clock to bus cycles only
  assign bus_timing_clock_out = bus_timing_clock & (~clock_stretch_control | bus_cycle_active);

  // tag sampled on E rise, strobe launched on E fall
  always @(posedge clk_sys) begin
    if (rst) begin
      bus_timing_clock_prev <= 1'b0;
      strobe_hold <= 1'b1;
      low_tag_input <= 1'b0;
    end else begin
      bus_timing_clock_prev <= bus_timing_clock;
      if (bus_timing_clock_fall) begin
        strobe_hold <= low_byte_strobe;
      end
      if (bus_timing_clock_rise && tag_enable && alt_sel[`PEFS_BIT_LSTR]) begin
        low_tag_input <= pin_state[`PEFS_BIT_LSTR];
      end
    end
  end

  always @* begin
    alt_sel = 8'h00;
    alt_value = 8'h00;
    alt_oe = 8'h00;
    // bit low turns pin 7 into free-cycle flag
    alt_sel[7] = bus_mode & ~free_cycle_output_enable;
    alt_value[7] = free_cycle;
    alt_oe[7] = 1'b1;
    // pins 6:5 show instruction queue state
    alt_sel[6] = bus_mode & pipe_status_output_enable;
    alt_sel[5] = bus_mode & pipe_status_output_enable;
    alt_value[6] = pipe_status_high;
    alt_value[5] = pipe_status_low;
    alt_oe[6] = 1'b1;
    alt_oe[5] = 1'b1;
    // pin 4 is the E clock unless disabled, any mode
    alt_sel[4] = ~bus_clock_pin_disable;
    alt_value[4] = bus_timing_clock_out;
    alt_oe[4] = 1'b1;
    // strobe inert in single, peripheral and normal narrow
    alt_sel[3] = bus_mode & (mode != `PEFS_MODE_NORMAL_NARROW) & low_strobe_enable;
    // pin released while E high so the tag can be read
    alt_value[3] = tag_enable ? strobe_hold : low_byte_strobe;
    alt_oe[3] = ~(tag_enable & bus_timing_clock);
    alt_sel[2] = bus_mode & read_write_pin_enable;
    alt_value[2] = read_write;
    alt_oe[2] = 1'b1;
  end

  // pins 1:0 are input only whatever the direction bits say
  pefs_pin_mux #(
    .WIDTH(8)
  ) u_mux (
    .alt_sel(alt_sel),
    .alt_value(alt_value),
    .alt_oe(alt_oe),
    .gpio_value(port_e_data),
    .gpio_dir(port_e_direction),
    .gpio_capable(8'hfc),
    .pin_value(mux_value),
    .pin_oe(mux_oe)
  );

  // registered pin drive, direction already overridden
  always @(posedge clk_sys) begin
    if (rst) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
    end else begin
      pin_out <= mux_value;
      pin_oe <= mux_oe;
    end
  end

endmodule

`default_nettype wire
